// ---- design/afrt_pkg.sv ----
/*
 * shared constants and carrier types of the ascii frame reply timing block.
 * assumes a 20 MHz system clock and a byte-wide uart on the same clock.
 */
package afrt_pkg;
  // timebase
  localparam int CLK_HZ = 20_000_000;
  localparam int MS_PER_S = 1000;
  localparam int MS_CYCLES_DEF = CLK_HZ / MS_PER_S;
  localparam int PROC_LIMIT_MS = 10;
  localparam int TURN_MAX_MS = 5;

  // control characters, hex digit bounds and letter offset
  localparam logic [7:0] CH_SOH = 8'h01;
  localparam logic [7:0] CH_ETX = 8'h03;
  localparam logic [7:0] CH_ENQ = 8'h05;
  localparam logic [7:0] CH_ACK = 8'h06;
  localparam logic [7:0] CH_NAK = 8'h15;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_NINE = 8'h39;
  localparam logic [7:0] CH_UPPER_A = 8'h41;
  localparam logic [7:0] CH_UPPER_F = 8'h46;
  localparam logic [7:0] HEX_LETTER_OFS = 8'h37;

  // command letters
  localparam logic [7:0] CMD_FREQ_A = 8'h61;
  localparam logic [7:0] CMD_FREQ_E = 8'h65;
  localparam logic [7:0] CMD_RUN_F = 8'h66;
  localparam logic [7:0] CMD_RD_G = 8'h67;
  localparam logic [7:0] CMD_RD_K = 8'h6b;
  localparam logic [7:0] CMD_RESET_M = 8'h6d;

  // frame positions (index of the character within the frame)
  localparam logic [3:0] IDX_ST_HI = 4'h1;
  localparam logic [3:0] IDX_ST_LO = 4'h2;
  localparam logic [3:0] IDX_ENQ = 4'h3;
  localparam logic [3:0] IDX_CMD = 4'h4;
  localparam logic [3:0] IDX_DATA = 4'h5;
  localparam logic [3:0] IDX_ETX_DATA = 4'h9;
  localparam logic [3:0] IDX_MAX = 4'he;
  localparam logic [3:0] REPLY_LAST_SHORT = 4'h7;
  localparam logic [3:0] REPLY_LAST_DATA = 4'hb;

  // latest error codes
  localparam logic [7:0] ERR_CKSUM = 8'h47;
  localparam logic [7:0] ERR_PROC = 8'h49;
  localparam logic [7:0] ERR_FORMAT = 8'h4a;
  localparam logic [7:0] ERR_CMD = 8'h4b;

  typedef struct packed {
    logic [3:0] hi;
    logic [3:0] lo;
  } afrt_station_t;

  typedef struct packed {
    logic [7:0] cmd;
    logic [15:0] data;
    logic bcast;
  } afrt_exec_req_t;

  typedef struct packed {
    logic ok;
    logic [7:0] err;
    logic [15:0] rdata;
  } afrt_exec_rsp_t;

  typedef enum logic [2:0] {
    ST_RX, ST_WAIT_IVL, ST_EXEC, ST_SEND, ST_TURN
  } afrt_state_e_t;

  typedef struct packed {
    afrt_state_e_t st;
    logic [3:0] idx;
    logic [7:0] sum;
    logic [7:0] cmd;
    logic [15:0] data;
    logic mine;
    logic bcast;
    logic enq_ok;
    logic hex_ok;
    logic [3:0] etx_idx;
    logic ck_hi_ok;
    logic do_exec;
    logic nak;
    logic [15:0] rdata;
    logic [7:0] reply_err;
    logic [7:0] last_err;
    logic [15:0] ms_cnt;
    logic [15:0] div;
    logic tx_en;
    logic [7:0] tx_byte;
    logic exec_req;
  } afrt_regs_t;
endpackage

// ---- design/afrt_responder.sv ----
/*
 * slave side of the ascii short-form frame protocol: receives request
 * frames, waits the reply interval, hands the command to the executor,
 * and, for frames to its own station with a good checksum, sends an ack or nak frame, keeping the driver turnaround bounded.
 * assumes a uart on clk_sys_i that delivers received bytes with a pulse,
 * takes bytes with valid/ready and reports when its shifter is idle.
 */
`timescale 1ns/10ps
module afrt_responder #(
  parameter int MS_CYCLES = afrt_pkg::MS_CYCLES_DEF,
  parameter int IVL_W = 8
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // configuration
  input wire afrt_pkg::afrt_station_t station_i,
  input wire logic [IVL_W-1:0] reply_interval_setting_i,
  // received bytes from the uart
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  // bytes to the uart transmitter
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  input wire logic tx_idle_i,
  output logic tx_en_o,
  output logic rx_en_o,
  // command executor
  output logic exec_req_o,
  output afrt_pkg::afrt_exec_req_t exec_o,
  input wire logic exec_done_i,
  input wire afrt_pkg::afrt_exec_rsp_t exec_rsp_i,
  // status
  output logic [7:0] latest_comm_error_code_o
);
  import afrt_pkg::*;

  afrt_regs_t r_ff;
  afrt_regs_t nxt_r;
  logic ms_tick;

  function automatic logic [7:0] hex_char(input logic [3:0] n);
    hex_char = (n > 4'h9) ? 8'({4'h0, n}) + HEX_LETTER_OFS
                          : 8'({4'h0, n}) + CH_ZERO;
  endfunction

  function automatic logic hex_valid(input logic [7:0] c);
    hex_valid = (c >= CH_ZERO && c <= CH_NINE) ||
                (c >= CH_UPPER_A && c <= CH_UPPER_F);
  endfunction

  function automatic logic [3:0] hex_val(input logic [7:0] c);
    hex_val = (c >= CH_UPPER_A) ? 4'(c - HEX_LETTER_OFS) : 4'(c - CH_ZERO);
  endfunction

  function automatic logic is_write(input logic [7:0] c);
    is_write = (c == CMD_FREQ_A) || (c == CMD_FREQ_E) || (c == CMD_RUN_F);
  endfunction

  function automatic logic is_read(input logic [7:0] c);
    is_read = (c >= CMD_RD_G) && (c <= CMD_RD_K);
  endfunction

  function automatic logic reply_has_data(input afrt_regs_t s);
    reply_has_data = is_read(s.cmd) && !s.nak;
  endfunction

  // character n of the reply, given the checksum of what went before
  function automatic logic [7:0] reply_byte(input afrt_regs_t s,
                                            input logic [3:0] n,
                                            input logic [7:0] sum);
    logic [3:0] etx;
    etx = reply_has_data(s) ? IDX_ETX_DATA : IDX_DATA;
    if (n == 4'h0) begin
      reply_byte = CH_SOH;
    end else if (n == IDX_ST_HI) begin
      reply_byte = CH_ZERO + 8'({4'h0, station_i.hi});
    end else if (n == IDX_ST_LO) begin
      reply_byte = CH_ZERO + 8'({4'h0, station_i.lo});
    end else if (n == IDX_ENQ) begin
      reply_byte = s.nak ? CH_NAK : CH_ACK;
    end else if (n == IDX_CMD) begin
      reply_byte = s.cmd;
    end else if (n < etx) begin
      reply_byte = hex_char(s.rdata[4'(4'h3 - (n - IDX_DATA)) * 4 +: 4]);
    end else if (n == etx) begin
      reply_byte = CH_ETX;
    end else if (n == etx + 4'h1) begin
      reply_byte = hex_char(sum[7:4]);
    end else begin
      reply_byte = hex_char(sum[3:0]);
    end
  endfunction

  assign ms_tick = (r_ff.div == 16'(MS_CYCLES - 1));

  always_comb begin
    logic [7:0] b;
    logic ck_ok;
    logic fmt_err;
    logic [3:0] last;
    b = rx_data_i;
    ck_ok = 1'b0;
    fmt_err = 1'b0;
    last = 4'h0;
    nxt_r = r_ff;
    nxt_r.exec_req = 1'b0;
    nxt_r.div = ms_tick ? 16'h0000 : r_ff.div + 16'h0001;
    if (ms_tick) begin
      nxt_r.ms_cnt = r_ff.ms_cnt + 16'h0001;
    end
    case (r_ff.st)
      ST_RX: begin
        if (rx_valid_i && b == CH_SOH) begin
          nxt_r.idx = IDX_ST_HI;
          nxt_r.sum = 8'h00;
          nxt_r.etx_idx = 4'h0;
          nxt_r.hex_ok = 1'b1;
          nxt_r.data = 16'h0000;
        end else if (rx_valid_i && r_ff.idx != 4'h0) begin
          nxt_r.idx = r_ff.idx + 4'h1;
          if (r_ff.etx_idx == 4'h0) begin
            nxt_r.sum = r_ff.sum + b;
          end
          if (r_ff.idx == IDX_ST_HI) begin
            nxt_r.mine = (b == CH_ZERO + 8'({4'h0, station_i.hi}));
            nxt_r.bcast = (b == CH_NINE);
          end else if (r_ff.idx == IDX_ST_LO) begin
            nxt_r.mine = r_ff.mine &&
                         (b == CH_ZERO + 8'({4'h0, station_i.lo}));
            nxt_r.bcast = r_ff.bcast && (b == CH_NINE);
          end else if (r_ff.idx == IDX_ENQ) begin
            nxt_r.enq_ok = (b == CH_ENQ);
          end else if (r_ff.idx == IDX_CMD) begin
            nxt_r.cmd = b;
          end else if (r_ff.etx_idx == 4'h0) begin
            if (b == CH_ETX) begin
              nxt_r.etx_idx = r_ff.idx;
            end else if (r_ff.idx == IDX_MAX) begin
              nxt_r.idx = 4'h0; // no etx in time: drop silently
            end else begin
              nxt_r.hex_ok = r_ff.hex_ok && hex_valid(b);
              nxt_r.data = {r_ff.data[11:0], hex_val(b)};
            end
          end else if (r_ff.idx == r_ff.etx_idx + 4'h1) begin
            nxt_r.ck_hi_ok = (b == hex_char(r_ff.sum[7:4]));
          end else begin
            nxt_r.idx = 4'h0;
            ck_ok = r_ff.ck_hi_ok && (b == hex_char(r_ff.sum[3:0]));
            fmt_err = !r_ff.enq_ok || !r_ff.hex_ok ||
                      (r_ff.etx_idx != IDX_DATA &&
                       r_ff.etx_idx != IDX_ETX_DATA) ||
                      (is_write(r_ff.cmd) &&
                       r_ff.etx_idx != IDX_ETX_DATA) ||
                      ((is_read(r_ff.cmd) || r_ff.cmd == CMD_RESET_M) &&
                       r_ff.etx_idx != IDX_DATA);
            if (r_ff.mine || r_ff.bcast) begin
              nxt_r.nak = 1'b0;
              nxt_r.do_exec = 1'b1;
              nxt_r.div = 16'h0000;
              nxt_r.ms_cnt = 16'h0000;
              nxt_r.st = ST_WAIT_IVL;
              if (!ck_ok) begin
                nxt_r.last_err = ERR_CKSUM;
                nxt_r.st = ST_RX;
              end else if (fmt_err || !(is_write(r_ff.cmd) ||
                           is_read(r_ff.cmd) ||
                           r_ff.cmd == CMD_RESET_M)) begin
                nxt_r.nak = 1'b1;
                nxt_r.do_exec = 1'b0;
                nxt_r.reply_err = fmt_err ? ERR_FORMAT : ERR_CMD;
                nxt_r.last_err = fmt_err ? ERR_FORMAT : ERR_CMD;
                if (r_ff.bcast) begin
                  nxt_r.st = ST_RX;
                end
              end
            end
          end
        end
      end
      ST_WAIT_IVL: begin
        if (r_ff.ms_cnt >= 16'(reply_interval_setting_i)) begin
          nxt_r.ms_cnt = 16'h0000;
          nxt_r.div = 16'h0000;
          if (r_ff.do_exec) begin
            nxt_r.exec_req = 1'b1;
            nxt_r.st = ST_EXEC;
          end else begin
            nxt_r.st = ST_SEND;
            nxt_r.idx = 4'h0;
            nxt_r.sum = 8'h00;
            nxt_r.tx_en = 1'b1;
            nxt_r.tx_byte = CH_SOH;
          end
        end
      end
      ST_EXEC: begin
        if (exec_done_i || r_ff.ms_cnt >= 16'(PROC_LIMIT_MS)) begin
          nxt_r.nak = !(exec_done_i && exec_rsp_i.ok);
          nxt_r.rdata = exec_rsp_i.rdata;
          nxt_r.reply_err = exec_done_i ? exec_rsp_i.err : ERR_PROC;
          if (!(exec_done_i && exec_rsp_i.ok)) begin
            nxt_r.last_err = exec_done_i ? exec_rsp_i.err : ERR_PROC;
          end
          nxt_r.idx = 4'h0;
          nxt_r.sum = 8'h00;
          nxt_r.tx_byte = CH_SOH;
          nxt_r.tx_en = !r_ff.bcast;
          nxt_r.st = r_ff.bcast ? ST_RX : ST_SEND;
        end
      end
      ST_SEND: begin
        if (tx_ready_i) begin
          last = reply_has_data(r_ff) ? REPLY_LAST_DATA : REPLY_LAST_SHORT;
          nxt_r.idx = r_ff.idx + 4'h1;
          if (r_ff.idx != 4'h0 && r_ff.tx_byte != CH_ETX &&
              r_ff.idx < last - 4'h1) begin
            nxt_r.sum = r_ff.sum + r_ff.tx_byte;
          end else if (r_ff.tx_byte == CH_ETX) begin
            nxt_r.sum = r_ff.sum + r_ff.tx_byte;
          end
          nxt_r.tx_byte = reply_byte(r_ff, r_ff.idx + 4'h1, nxt_r.sum);
          if (r_ff.idx == last) begin
            nxt_r.idx = 4'h0;
            nxt_r.ms_cnt = 16'h0000;
            nxt_r.div = 16'h0000;
            nxt_r.st = ST_TURN;
          end
        end
      end
      ST_TURN: begin
        if (tx_idle_i || r_ff.ms_cnt >= 16'(TURN_MAX_MS - 1)) begin
          nxt_r.tx_en = 1'b0;
          nxt_r.st = ST_RX;
        end
      end
      default: begin
        nxt_r.st = ST_RX;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      r_ff <= '0;
      r_ff.st <= ST_RX;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign tx_valid_o = (r_ff.st == ST_SEND);
  assign tx_data_o = r_ff.tx_byte;
  assign tx_en_o = r_ff.tx_en;
  assign rx_en_o = !r_ff.tx_en;
  assign exec_req_o = r_ff.exec_req;
  assign exec_o = '{cmd: r_ff.cmd, data: r_ff.data, bcast: r_ff.bcast};
  assign latest_comm_error_code_o = r_ff.last_err;
endmodule

// ---- verif/afrt_far_model.sv ----
/* far side of the responder: uart transmitter and command executor.
   assumes the testbench sets the executor latency and answer. */
`timescale 1ns/10ps
module afrt_far_model
  import afrt_pkg::*;
(
  // clock
  input wire logic clk_sys_i,
  // uart transmitter
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  output logic tx_ready_o,
  output logic tx_idle_o,
  // executor
  input wire logic exec_req_i,
  output logic exec_done_o,
  output afrt_pkg::afrt_exec_rsp_t exec_rsp_o,
  // scenario controls, latency ffff never answers
  input wire logic [15:0] lat_i,
  input wire afrt_pkg::afrt_exec_rsp_t rsp_i
);
  logic [7:0] got[$];
  int busy = 0;
  int left = -1;
  initial begin
    tx_ready_o = 1'b0;
    tx_idle_o = 1'b1;
    exec_done_o = 1'b0;
    exec_rsp_o = '0;
  end
  always @(posedge clk_sys_i) begin
    exec_done_o <= 1'b0;
    exec_rsp_o <= ~exec_rsp_o;
    if (tx_valid_i && tx_ready_o) begin
      got.push_back(tx_data_i);
      busy <= 3;
      tx_ready_o <= 1'b0;
      tx_idle_o <= 1'b0;
    end else if (busy > 0) begin
      busy <= busy - 1;
    end else begin
      tx_ready_o <= 1'b1;
      tx_idle_o <= 1'b1;
    end
    if (exec_req_i) begin
      left <= int'(lat_i);
    end else if (left == 0) begin
      exec_done_o <= 1'b1;
      exec_rsp_o <= rsp_i;
      left <= -1;
    end else if (left > 0 && lat_i != 16'hffff) begin
      left <= left - 1;
    end
  end
endmodule

// ---- verif/afrt_responder_props.sv ----
/* assertions on reply framing and timing of the responder.
   assumes a bind onto afrt_responder, single clock domain. */
`timescale 1ns/10ps
module afrt_responder_props
  import afrt_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DEF,
  parameter int IVL_W = 8
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // watched ports
  input wire logic [IVL_W-1:0] reply_interval_setting_i,
  input wire logic rx_valid_i,
  input wire logic tx_valid_o,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  input wire logic tx_idle_i,
  input wire logic tx_en_o,
  input wire logic rx_en_o,
  input wire logic exec_req_o,
  input wire afrt_pkg::afrt_exec_req_t exec_o
);
  logic [31:0] since_ff;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  // cycles since the last received byte
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || rx_valid_i) since_ff <= 32'h0;
    else if (since_ff != 32'hffffffff) since_ff <= since_ff + 32'h1;
  end
  rx_tx_excl_a: assert property (rx_en_o != tx_en_o)
    else $error("rx enable not inverse of tx enable");
  send_en_a: assert property (tx_valid_o |-> tx_en_o)
    else $error("byte offered with driver off");
  reply_start_a: assert property ($rose(tx_valid_o) |->
    tx_data_o == CH_SOH && $rose(tx_en_o))
    else $error("reply does not open with soh");
  byte_hold_a: assert property (tx_valid_o && !tx_ready_i |=>
    tx_valid_o && $stable(tx_data_o))
    else $error("offered byte changed before taken");
  exec_pulse_a: assert property (exec_req_o |->
    !tx_en_o ##1 !exec_req_o)
    else $error("exec request not a lone pulse");
  turn_end_a: assert property (tx_en_o && !tx_valid_o &&
    tx_idle_i |=> !tx_en_o)
    else $error("driver held after shifter idle");
  bcast_quiet_a: assert property (exec_req_o && exec_o.bcast |=>
    !tx_en_o [*8])
    else $error("broadcast answered");
  ivl_hold_a: assert property (exec_req_o |-> since_ff + 32'h1 >=
    32'(reply_interval_setting_i) * MS_CYCLES)
    else $error("reply interval cut short");
  cover property (exec_req_o && exec_o.bcast);
  cover property (tx_valid_o && !tx_ready_i);
  cover property ($fell(tx_en_o));
endmodule
bind afrt_responder afrt_responder_props #(.MS_CYCLES(MS_CYCLES),
  .IVL_W(IVL_W)) u_props (.clk_sys_i, .rst_n_i,
  .reply_interval_setting_i, .rx_valid_i, .tx_valid_o, .tx_data_o,
  .tx_ready_i, .tx_idle_i, .tx_en_o, .rx_en_o, .exec_req_o, .exec_o);

// ---- verif/afrt_responder_tb_top.sv ----
/* self-checking bench of the responder, host role played here.
   assumes afrt_far_model as uart and executor. */
`timescale 1ns/10ps
module afrt_responder_tb_top;
  import afrt_pkg::*;
  localparam int MS = 20;
  logic clk_sys_i, rst_n_i, rx_valid, tx_valid, tx_ready, tx_idle;
  logic tx_en, rx_en, exec_req, exec_done;
  logic [7:0] ivl, rx_data, tx_data, code;
  logic [15:0] lat;
  afrt_station_t station;
  afrt_exec_req_t exec;
  afrt_exec_rsp_t exec_rsp, rsp;
  int err_total = 0;
  int checks = 0;
  afrt_responder #(.MS_CYCLES(MS), .IVL_W(8)) dut (.clk_sys_i, .rst_n_i,
    .station_i(station), .reply_interval_setting_i(ivl),
    .rx_valid_i(rx_valid), .rx_data_i(rx_data), .tx_valid_o(tx_valid),
    .tx_data_o(tx_data), .tx_ready_i(tx_ready), .tx_idle_i(tx_idle),
    .tx_en_o(tx_en), .rx_en_o(rx_en), .exec_req_o(exec_req),
    .exec_o(exec), .exec_done_i(exec_done), .exec_rsp_i(exec_rsp),
    .latest_comm_error_code_o(code));
  afrt_far_model u_far (.clk_sys_i, .tx_valid_i(tx_valid),
    .tx_data_i(tx_data), .tx_ready_o(tx_ready), .tx_idle_o(tx_idle),
    .exec_req_i(exec_req), .exec_done_o(exec_done),
    .exec_rsp_o(exec_rsp), .lat_i(lat), .rsp_i(rsp));
  always #25 clk_sys_i = ~clk_sys_i;
  task automatic summarize;
    if (err_total == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  function automatic logic [7:0] hx(input logic [3:0] n);
    return {4'h0, n} + ((n < 4'ha) ? 8'h30 : 8'h37);
  endfunction
  task automatic send(input logic [7:0] sh, sl, c, input bit hd,
                      input logic [15:0] d, input bit bad);
    logic [7:0] q[$];
    logic [7:0] s;
    repeat (6 * MS) @(negedge clk_sys_i);
    q = {CH_SOH, sh, sl, CH_ENQ, c};
    if (hd) q = {q, hx(d[15:12]), hx(d[11:8]), hx(d[7:4]), hx(d[3:0])};
    q.push_back(CH_ETX);
    s = {7'h0, bad};
    foreach (q[i]) if (i > 0) s += q[i];
    q = {q, hx(s[7:4]), hx(s[3:0])};
    foreach (q[i]) begin
      @(negedge clk_sys_i);
      rx_valid = 1'b1;
      rx_data = q[i];
      @(negedge clk_sys_i);
      rx_valid = 1'b0;
    end
    u_far.got.delete();
  endtask
  // waits for the whole reply under the host timeout, then compares
  task automatic reply(input logic [7:0] ak, c, input bit rd,
                       input logic [15:0] v);
    logic [7:0] e[$];
    logic [7:0] s;
    int n;
    e = {8'h31, 8'h32, ak, c};
    if (rd) e = {e, hx(v[15:12]), hx(v[11:8]), hx(v[7:4]), hx(v[3:0])};
    e.push_back(CH_ETX);
    s = 8'h00;
    foreach (e[i]) s += e[i];
    e = {CH_SOH, e, hx(s[7:4]), hx(s[3:0])};
    n = 0;
    while (!(u_far.got.size() == e.size() && rx_en === 1'b1)) begin
      @(negedge clk_sys_i);
      n++;
      if (n > (100 + int'(ivl)) * MS) begin
        err_total++;
        $display("wrong value at %0t: got %h exp %h", $time,
                 u_far.got.size(), e.size());
        summarize();
      end
    end
    foreach (e[i]) chk(u_far.got[i], e[i]);
  endtask
  task automatic quiet;
    repeat (15 * MS) @(negedge clk_sys_i);
    chk(u_far.got.size(), 0);
  endtask
  task automatic t_cmds;
    logic [7:0] cl[9] = '{8'h61, 8'h65, 8'h66, 8'h67, 8'h68, 8'h69,
                          8'h6a, 8'h6b, 8'h6d};
    rsp = {1'b1, 8'h00, 16'h0bb8};
    for (int i = 0; i < 9; i++) begin
      send(8'h31, 8'h32, cl[i], i < 3, 16'h1a0b, 0);
      reply(CH_ACK, cl[i], i > 2 && i < 8, 16'h0bb8);
      if (i < 3) chk({exec.cmd, exec.data}, {cl[i], 16'h1a0b});
    end
  endtask
  task automatic t_ivl;
    int n;
    ivl = 8'd3;
    send(8'h31, 8'h32, 8'h66, 1, 16'h0002, 0);
    for (n = 0; n < 200 && tx_valid !== 1'b1; n++) @(negedge clk_sys_i);
    chk(n >= 3 * MS - 1 && n <= 3 * MS + 8, 1);
    reply(CH_ACK, 8'h66, 0, 0);
    ivl = 8'd0;
  endtask
  task automatic t_nak;
    rsp = {1'b0, 8'h4c, 16'h0000};
    send(8'h31, 8'h32, 8'h66, 1, 16'h0001, 0);
    reply(CH_NAK, 8'h66, 0, 0);
    chk(code, 8'h4c);
    send(8'h31, 8'h32, 8'h66, 0, 0, 0);
    reply(CH_NAK, 8'h66, 0, 0);
    chk(code, ERR_FORMAT);
    send(8'h31, 8'h32, 8'h7a, 0, 0, 0);
    reply(CH_NAK, 8'h7a, 0, 0);
    chk(code, ERR_CMD);
  endtask
  task automatic t_bcast;
    rsp = {1'b1, 8'h00, 16'h0000};
    send(8'h39, 8'h39, 8'h66, 1, 16'h0002, 0);
    quiet();
    chk({exec.bcast, exec.data}, {1'b1, 16'h0002});
    send(8'h33, 8'h34, 8'h66, 1, 16'h0001, 0);
    quiet();
    send(8'h31, 8'h32, 8'h66, 1, 16'h0001, 1);
    quiet();
    chk(code, ERR_CKSUM);
  endtask
  task automatic t_slow;
    lat = 16'hffff;
    send(8'h31, 8'h32, 8'h67, 0, 0, 0);
    reply(CH_NAK, 8'h67, 0, 0);
    chk(code, ERR_PROC);
    lat = 16'd2;
  endtask
  // corrupted first try gets no reply: host times out, polls, resends
  task automatic t_retry;
    int tries;
    rsp = {1'b1, 8'h00, 16'h0000};
    for (tries = 0; tries < 3; tries++) begin
      send(8'h31, 8'h32, 8'h66, 1, 16'h0003, tries == 0);
      repeat (100 * MS) @(negedge clk_sys_i);
      if (u_far.got.size() != 0) break;
      chk(code, ERR_CKSUM);
    end
    chk(tries, 1);
    reply(CH_ACK, 8'h66, 0, 0);
    chk({exec.cmd, exec.data}, {8'h66, 16'h0003});
  endtask
  initial begin
    clk_sys_i = 1'b0;
    rst_n_i = 1'b0;
    station = 8'h12;
    ivl = 8'd0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    lat = 16'd2;
    rsp = '0;
    repeat (5) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    chk({code, rx_en, tx_en, exec_req}, {8'h00, 3'b100});
    t_cmds();
    t_ivl();
    t_nak();
    t_bcast();
    t_slow();
    t_retry();
    summarize();
  end
endmodule
